/* File: design/wwrs_pkg.sv */
// Package with timing constants and states of the wakeup watchdog reset supervisor
package wwrs_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 40000000;
  // Timing resistor in ohms, default value
  localparam int unsigned RDELAY_OHM = 60000;
  // Seconds per ohm, scaled by 1e11 so the figures stay integer
  localparam longint unsigned WAKE_PER_OHM_E11 = 64'd41700;    // 4.17e-7
  localparam longint unsigned RSTDLY_PER_OHM_E11 = 64'd5210;   // 5.21e-8
  localparam longint unsigned WAKEDLY_PER_OHM_E11 = 64'd20800; // 2.08e-7
  localparam longint unsigned SCALE_E11 = 64'd100000000000;
  // Default period in cycles, derived from resistor and rate
  localparam longint unsigned WAKE_PERIOD_CYC_L =
    (WAKE_PER_OHM_E11 * RDELAY_OHM * CLK_HZ) / SCALE_E11;
  localparam int unsigned WAKE_PERIOD_CYC = int'(WAKE_PERIOD_CYC_L);
  // Cross-check figures, the block uses the base tick ratios
  localparam longint unsigned RST_DELAY_CYC_L =
    (RSTDLY_PER_OHM_E11 * RDELAY_OHM * CLK_HZ) / SCALE_E11;
  localparam longint unsigned WAKE_DELAY_CYC_L =
    (WAKEDLY_PER_OHM_E11 * RDELAY_OHM * CLK_HZ) / SCALE_E11;
  // Counter width
  localparam int unsigned CNT_W = 32;
  // Reset pulse on missed watchdog, in cycles
  localparam int unsigned WD_RST_PULSE_CYC = 1;
  // Supervisor states
  typedef enum logic [2:0] {
    WWRS_OFF,
    WWRS_HOLD,
    WWRS_DELAY,
    WWRS_PRE_WAKE,
    WWRS_RUN,
    WWRS_PULSE
  } wwrs_state_type;
endpackage

/* File: design/wwrs_edge.sv */
// Falling edge detector for the watchdog service input
`timescale 1ns/1ps
`default_nettype none
module wwrs_edge
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic sig_in,
  output logic      fall
);
  logic prev_q;

  // Remember last level
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= 1'b0;
    else
      prev_q <= sig_in;
  end

  assign fall = prev_q & ~sig_in;
endmodule
`default_nettype wire

/* File: design/wwrs_timer.sv */
// Down counter with load and expiry flag
`timescale 1ns/1ps
`default_nettype none
module wwrs_timer
#(
  parameter int unsigned W = 32
)
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic [W-1:0]      count,
  output logic              done
);
  logic [W-1:0] cnt_q;

  // Load or count down to zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (load)
      cnt_q <= load_val;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign count = cnt_q;
  // Expiry from the count alone, load is decided from it upstream
  assign done  = (cnt_q == '0);
endmodule
`default_nettype wire

/* File: design/wwrs_top.sv */
// Wakeup, watchdog and reset supervisor top
`timescale 1ns/1ps
`default_nettype none
module wwrs_top
#(
  parameter int unsigned WAKE_PERIOD_CYC = wwrs_pkg::WAKE_PERIOD_CYC
)
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic enable_in,
  input  wire logic out_uv_flag,
  input  wire logic in_low_flag,
  input  wire logic watchdog_service_in,
  output logic      pass_on,
  output logic      reset_out_n,
  output logic      wakeup_out
);
  localparam int unsigned W = wwrs_pkg::CNT_W;
  // Load values are one short: the expiry cycle itself counts as a cycle
  localparam logic [W-1:0] PERIOD   = W'(WAKE_PERIOD_CYC - 1);
  localparam logic [W-1:0] HALF     = W'(WAKE_PERIOD_CYC / 2);
  localparam logic [W-1:0] RST_DLY  = W'(WAKE_PERIOD_CYC / 8 - 1);
  localparam logic [W-1:0] WAKE_DLY = W'(WAKE_PERIOD_CYC / 2 - 1);
  localparam logic [W-1:0] PULSE    = W'(wwrs_pkg::WD_RST_PULSE_CYC - 1);

  wwrs_pkg::wwrs_state_type state_q;
  wwrs_pkg::wwrs_state_type state_d;
  logic         served_q;
  logic         served_d;
  logic         pass_q;
  logic         rstn_q;
  logic         rstn_d;
  logic         wake_q;
  logic         wake_d;
  logic         tload;
  logic [W-1:0] tval;
  logic [W-1:0] tcount;
  logic         tdone;
  logic         wd_fall;
  logic         abort;
  logic         in_first_half;
  logic         svc_ok;

  // Service edge detector
  wwrs_edge u_edge
  (
    .clock  (clock),
    .rst_n  (rst_n),
    .sig_in (watchdog_service_in),
    .fall   (wd_fall)
  );

  // Shared interval timer
  wwrs_timer #(.W(W)) u_timer
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (tload),
    .load_val (tval),
    .count    (tcount),
    .done     (tdone)
  );

  // Conditions that force reset
  assign abort         = ~enable_in | out_uv_flag | in_low_flag;
  assign in_first_half = (tcount > HALF);
  assign svc_ok        = wd_fall & ~served_q;

  // Next state and timer control
  always_comb
  begin
    state_d  = state_q;
    served_d = served_q;
    tload    = 1'b0;
    tval     = PERIOD;
    rstn_d   = 1'b0;
    wake_d   = 1'b0;
    case (state_q)
      wwrs_pkg::WWRS_OFF:
      begin
        if (enable_in)
          state_d = wwrs_pkg::WWRS_HOLD;
      end
      wwrs_pkg::WWRS_HOLD:
      begin
        if (!abort)
        begin
          state_d = wwrs_pkg::WWRS_DELAY;
          tload   = 1'b1;
          tval    = RST_DLY;
        end
      end
      wwrs_pkg::WWRS_DELAY:
      begin
        if (tdone)
        begin
          state_d = wwrs_pkg::WWRS_PRE_WAKE;
          rstn_d  = 1'b1;
          tload   = 1'b1;
          tval    = WAKE_DLY;
        end
      end
      wwrs_pkg::WWRS_PRE_WAKE:
      begin
        rstn_d = 1'b1;
        if (tdone)
        begin
          state_d  = wwrs_pkg::WWRS_RUN;
          served_d = 1'b0;
          tload    = 1'b1;
          tval     = PERIOD;
          wake_d   = 1'b1;
        end
      end
      wwrs_pkg::WWRS_RUN:
      begin
        rstn_d = 1'b1;
        if (svc_ok)
          served_d = 1'b1;
        if (tdone)
        begin
          if (served_q || svc_ok)
          begin
            state_d  = wwrs_pkg::WWRS_RUN;
            served_d = 1'b0;
            tload    = 1'b1;
            tval     = PERIOD;
            wake_d   = 1'b1;
          end
          else
          begin
            state_d = wwrs_pkg::WWRS_PULSE;
            rstn_d  = 1'b0;
            tload   = 1'b1;
            tval    = PULSE;
          end
        end
        else
          wake_d = in_first_half & ~served_q & ~svc_ok;
      end
      wwrs_pkg::WWRS_PULSE:
      begin
        if (tdone)
        begin
          state_d = wwrs_pkg::WWRS_PRE_WAKE;
          rstn_d  = 1'b1;
          tload   = 1'b1;
          tval    = WAKE_DLY;
        end
      end
      default:
        state_d = wwrs_pkg::WWRS_OFF;
    endcase
    if (!enable_in)
    begin
      state_d = wwrs_pkg::WWRS_OFF;
      rstn_d  = 1'b0;
      wake_d  = 1'b0;
    end
    else if (abort && state_q != wwrs_pkg::WWRS_OFF)
    begin
      state_d = wwrs_pkg::WWRS_HOLD;
      rstn_d  = 1'b0;
      wake_d  = 1'b0;
    end
    if (!rstn_d)
      wake_d = 1'b0;
  end

  // State and output registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= wwrs_pkg::WWRS_OFF;
      served_q <= 1'b0;
      pass_q   <= 1'b0;
      rstn_q   <= 1'b0;
      wake_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      served_q <= served_d;
      pass_q   <= enable_in;
      rstn_q   <= rstn_d;
      wake_q   <= wake_d;
    end
  end

  assign pass_on     = pass_q;
  assign reset_out_n = rstn_q;
  assign wakeup_out  = wake_q;
endmodule
`default_nettype wire

/* File: bench/wwrs_asserts.sv */
// Checker of the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module wwrs_asserts
#(
  parameter int unsigned WAKE_PERIOD_CYC = 64
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable_in,
  input wire logic out_uv_flag,
  input wire logic in_low_flag,
  input wire logic watchdog_service_in,
  input wire logic pass_on,
  input wire logic reset_out_n,
  input wire logic wakeup_out
);
  // Supervisor relations, one clock
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_uv_resets: assert property (out_uv_flag |=> !reset_out_n)
    else $error("no reset on undervoltage");
  a_low_resets: assert property (in_low_flag |=> !reset_out_n)
    else $error("no reset on low input");
  a_off_shutdown: assert property (!enable_in |=> !pass_on && !reset_out_n)
    else $error("enable low not in shutdown");
  a_reset_wake_low: assert property (!reset_out_n && $past(!reset_out_n) |-> !wakeup_out)
    else $error("wakeup high in reset");
  a_release_delay: assert property ($rose(reset_out_n)
    |-> $past(!out_uv_flag && !in_low_flag, 8))
    else $error("reset released early");
  a_wake_delay: assert property ($rose(reset_out_n) |-> ##[30:36] $rose(wakeup_out))
    else $error("first wakeup off time");
  a_service_low: assert property (wakeup_out && $fell(watchdog_service_in)
    |-> ##[1:3] !wakeup_out)
    else $error("wakeup not forced low");
  a_miss_pulse: assert property ($fell(reset_out_n) && pass_on && !out_uv_flag
    && !in_low_flag |-> ##[1:3] reset_out_n)
    else $error("missed service pulse length");
endmodule
bind wwrs_top wwrs_asserts #(.WAKE_PERIOD_CYC(WAKE_PERIOD_CYC)) u_chk (.clock(clock),
  .rst_n(rst_n), .enable_in(enable_in), .out_uv_flag(out_uv_flag), .in_low_flag(in_low_flag),
  .watchdog_service_in(watchdog_service_in), .pass_on(pass_on), .reset_out_n(reset_out_n),
  .wakeup_out(wakeup_out));
`default_nettype wire

/* File: bench/wwrs_mcu.sv */
// Controller model answering wakeup with watchdog pulses
`timescale 1ns/1ps
`default_nettype none
module wwrs_mcu
(
  input  wire logic clock,
  input  wire logic wakeup_out,
  input  wire logic serve,
  output var logic  watchdog_service_in
);
  // Idle high; two pulses after each wakeup rise while serve is high
  initial
  begin
    watchdog_service_in = 1'b1;
    forever
    begin
      @(posedge wakeup_out);
      if (serve)
      begin
        repeat (2)
        begin
          repeat (3) @(posedge clock);
          #2 watchdog_service_in = 1'b0;
          repeat (2) @(posedge clock);
          #2 watchdog_service_in = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/wwrs_top_tb.sv */
// Self-checking bench of the supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module wwrs_top_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic enable_in = 1'b1;
  logic out_uv_flag = 1'b1;
  logic in_low_flag = 1'b0;
  logic serve = 1'b1;
  logic watchdog_service_in, pass_on, reset_out_n, wakeup_out;
  int errors = 0;
  int checks_done = 0;
  int n, m;
  wwrs_top #(.WAKE_PERIOD_CYC(64)) dut (.clock(clock), .rst_n(rst_n), .enable_in(enable_in),
    .out_uv_flag(out_uv_flag), .in_low_flag(in_low_flag),
    .watchdog_service_in(watchdog_service_in), .pass_on(pass_on),
    .reset_out_n(reset_out_n), .wakeup_out(wakeup_out));
  wwrs_mcu u_mcu (.clock(clock), .wakeup_out(wakeup_out), .serve(serve),
    .watchdog_service_in(watchdog_service_in));
  // Clock, 25 ns
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  task complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(posedge clock);
    #2;
  endtask
  // Cycles until reset (s 0) or wakeup (s 1) reaches v
  task wsig(input int s, input logic v, output int c);
    c = 0;
    while (((s == 0) ? reset_out_n : wakeup_out) !== v)
    begin
      tick(1);
      c++;
      if (c > 300)
      begin
        errors++;
        complete_run();
      end
    end
  endtask
  task t_power;
    tick(20);
    `CHK(reset_out_n, 1'b0)
    `CHK(pass_on, 1'b1)
    out_uv_flag = 1'b0;
    wsig(0, 1'b1, n);
    `CHK(n inside {[8:12]}, 1'b1)
    wsig(1, 1'b1, n);
    `CHK(n inside {[30:36]}, 1'b1)
    $display("t_power done");
  endtask
  task t_wake;
    wsig(1, 1'b0, n);
    `CHK(n < 8, 1'b1)
    wsig(1, 1'b1, m);
    `CHK(n + m, 64)
    `CHK(reset_out_n, 1'b1)
    $display("t_wake done");
  endtask
  task t_flags;
    in_low_flag = 1'b1;
    tick(2);
    `CHK({reset_out_n, wakeup_out}, 2'h0)
    in_low_flag = 1'b0;
    wsig(0, 1'b1, n);
    wsig(1, 1'b1, n);
    out_uv_flag = 1'b1;
    tick(20);
    `CHK({reset_out_n, wakeup_out}, 2'h0)
    out_uv_flag = 1'b0;
    wsig(0, 1'b1, n);
    `CHK(n inside {[8:12]}, 1'b1)
    wsig(1, 1'b1, n);
    $display("t_flags done");
  endtask
  task t_miss;
    serve = 1'b0;
    wsig(1, 1'b0, n);
    wsig(1, 1'b1, n);
    wsig(1, 1'b0, n);
    `CHK(n inside {[31:33]}, 1'b1)
    wsig(0, 1'b0, n);
    `CHK(n inside {[30:34]}, 1'b1)
    serve = 1'b1;
    wsig(0, 1'b1, n);
    `CHK(n < 4, 1'b1)
    wsig(1, 1'b1, n);
    $display("t_miss done");
  endtask
  task t_off;
    enable_in = 1'b0;
    tick(2);
    `CHK({pass_on, reset_out_n, wakeup_out}, 3'h0)
    enable_in = 1'b1;
    wsig(0, 1'b1, n);
    `CHK(pass_on, 1'b1)
    $display("t_off done");
  endtask
  // Main sequence
  initial
  begin
    tick(12);
    rst_n = 1'b1;
    t_power();
    t_wake();
    t_flags();
    t_miss();
    t_off();
    complete_run();
  end
endmodule
`default_nettype wire
